/* File: hdl/tpq_pkg.sv */
// Purpose: Shared constants and types of the transmit packet queue.
// Assumes: One 25 MHz clock, classic Wishbone register access, 32-bit data.
// Notes:   Packet numbers index fixed one-page packet buffers.
package tpq_pkg;
  // Sizes of the packet store and the queues
  localparam int PN_W     = 3;                  // Packet number width
  localparam int NPKT     = 8;                  // Packet buffers, also queue depth
  localparam int PTR_W    = 6;                  // Word pointer inside one buffer
  localparam int PG_BYTES = 256;                // Bytes held by one buffer
  localparam int CNT_W    = 11;                 // Width of the requested byte count
  localparam int DAT_W    = 32;                 // Bus and memory word width
  localparam int ADR_W    = 8;                  // Byte address width of the register map

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_CTRL  = 8'h00; // Transmit control
  localparam logic [ADR_W-1:0] OFS_CMD   = 8'h04; // Memory manager command
  localparam logic [ADR_W-1:0] OFS_ALLOC = 8'h08; // Allocation result
  localparam logic [ADR_W-1:0] OFS_PNR   = 8'h0c; // Packet number
  localparam logic [ADR_W-1:0] OFS_PTR   = 8'h10; // Word pointer
  localparam logic [ADR_W-1:0] OFS_DATA  = 8'h14; // Packet data window
  localparam logic [ADR_W-1:0] OFS_PORTS = 8'h18; // Queue heads
  localparam logic [ADR_W-1:0] OFS_ISTAT = 8'h1c; // Interrupt status
  localparam logic [ADR_W-1:0] OFS_IMASK = 8'h20; // Interrupt mask
  localparam logic [ADR_W-1:0] OFS_TXACK = 8'h24; // Transmit interrupt acknowledge
  localparam logic [ADR_W-1:0] OFS_LSTAT = 8'h28; // Link side status

  // Control register fields
  localparam int CTRL_TXEN = 0;                 // Transmit enable
  localparam int CTRL_AREL = 1;                 // Automatic release, fixed off
  localparam int CTRL_FDX  = 2;                 // Full duplex, no deferral wait
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Command register fields and codes
  localparam int CMD_CNT_LSB = 16;              // Byte count in [26:16]
  localparam logic [2:0] CMD_ALLOC   = 3'h1;
  localparam logic [2:0] CMD_RELEASE = 3'h2;
  localparam logic [2:0] CMD_ENQUEUE = 3'h3;

  // Allocation result fields
  localparam int ALLOC_FAIL = 7;                // Set when the last request failed
  localparam logic [7:0] ALLOC_RST = 8'h80;

  // Interrupt status and mask bits
  localparam int IRQ_ALLOC = 0;                 // Allocation done, sticky
  localparam int IRQ_TX    = 1;                 // Completion queue not empty, level
  localparam int IRQ_FAIL  = 2;                 // Transmit failure, sticky
  localparam logic [2:0] IMASK_RST = 3'h0;

  // Queue heads register fields
  localparam int PRT_CMP_EMPTY = 7;
  localparam int PRT_TX_LSB    = 8;
  localparam int PRT_TX_EMPTY  = 15;
  localparam int PRT_FAIL_LSB  = 16;

  // Transmit sequencer states
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_FINISH} tpq_tx_state_t;
endpackage

/* File: hdl/tpq_queue.sv */
// Purpose: Transmit packet queue with manual release, register slave and MAC hand-off.
// Assumes: MAC side signals are synchronous to clk_i; Wishbone classic slave.
// Notes:   One buffer page per packet; frames longer than a page are refused.
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none

// Small packet number queue, used for the transmit and the completion queue.
module tpq_fifo #(
  parameter int W = 3,                          // Entry width
  parameter int D = 8                           // Depth, power of two
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         push_i,             // Ignored while full
  input  wire logic [W-1:0] din_i,
  input  wire logic         pop_i,              // Ignored while empty
  output logic      [W-1:0] head_o,
  output logic              full_o,
  output logic              empty_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0] slot_q [D];                     // Entry storage
  logic [AW-1:0] wp_q;                          // Write pointer
  logic [AW-1:0] wp_d;
  logic [AW-1:0] rp_q;                          // Read pointer
  logic [AW-1:0] rp_d;
  logic [AW:0]   cnt_q;                         // Fill count
  logic [AW:0]   cnt_d;
  logic          do_push;
  logic          do_pop;

  // Pointer and count update; overflow and underflow are refused
  always_comb begin
    do_push = push_i & ~full_o; // RQ19
    do_pop  = pop_i & ~empty_o; // RQ19
    wp_d    = do_push ? wp_q + 1'b1 : wp_q;
    rp_d    = do_pop ? rp_q + 1'b1 : rp_q;
    cnt_d   = cnt_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  end

  // Pointer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage holds no control state, so it needs no reset
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      slot_q[wp_q] <= din_i;
    end
  end

  assign head_o  = slot_q[rp_q];
  assign full_o  = (cnt_q == (AW+1)'(D));
  assign empty_o = (cnt_q == '0);
endmodule // tpq_fifo

// Contract
// [RQ1] Auto release off; buffers kept after sending
// [RQ2] Allocate command reserves requested byte count
// [RQ3] Successful allocation sets allocation done flag
// [RQ4] Allocated number shown in allocation result
// [RQ5] Host loads number, pointer, then frame data
// [RQ6] Enqueue pushes packet number register value
// [RQ7] Queued packets complete without host help
// [RQ8] Hand-off needs enable and deferral permission
// [RQ9] Completion writes status into first word
// [RQ10] Completion moves number to completion queue
// [RQ11] Transmit interrupt while completion queue nonempty
// [RQ12] Failure interrupts, clears enable, halts sequence
// [RQ13] Failed packet number shown in ports register
// [RQ14] Host reads status, takes number, reloads it
// [RQ15] Loaded completed packet's status readable via data
// [RQ16] Release command frees that packet's buffer
// [RQ17] Acknowledge write pops completion queue head
// [RQ18] Host retries: check status, reload, re-enable
// [RQ19] Refuse push when full, pop when empty
module tpq_queue
  import tpq_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [DAT_W-1:0] wb_dat_i,
  output logic      [DAT_W-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  irq_o,
  output logic                  mac_req_o,       // Packet handed to the MAC
  output logic      [PN_W-1:0]  mac_pkt_o,       // Number of that packet
  input  wire logic [PTR_W-1:0] mac_rd_ptr_i,    // MAC frame read pointer
  output logic      [DAT_W-1:0] mac_rd_data_o,   // Frame word, one cycle later
  input  wire logic             mac_defer_ok_i,  // Deferral allows a start
  input  wire logic             mac_done_i,      // Transmission over, pulse
  input  wire logic             mac_fail_i,      // With done: it failed
  input  wire logic [DAT_W-1:0] mac_status_i     // With done: status word
);
  localparam int MW = PN_W + PTR_W;

  // Packet buffer memory, one page per packet number
  localparam int PG_WORDS = PG_BYTES / 4;        // Words in one buffer page
  logic [DAT_W-1:0] mem_q [NPKT*PG_WORDS];

  // Register state
  logic [2:0]       ctrl_q;                      // Control bits
  logic [2:0]       ctrl_d;
  logic [7:0]       alloc_q;                     // Allocation result
  logic [7:0]       alloc_d;
  logic [PN_W-1:0]  pnr_q;                       // Packet number register
  logic [PN_W-1:0]  pnr_d;
  logic [PTR_W-1:0] ptr_q;                       // Word pointer
  logic [PTR_W-1:0] ptr_d;
  logic [2:0]       istat_q;                     // Sticky interrupt bits
  logic [2:0]       istat_d;
  logic [2:0]       imask_q;                     // Interrupt mask
  logic [2:0]       imask_d;
  logic [NPKT-1:0]  used_q;                      // Allocated buffers
  logic [NPKT-1:0]  used_d;
  logic [PN_W-1:0]  fail_pn_q;                   // Last failed packet
  logic [PN_W-1:0]  fail_pn_d;
  logic [DAT_W-1:0] lstat_q;                     // Last status word
  logic [DAT_W-1:0] lstat_d;
  logic [DAT_W-1:0] dat_q;                       // Bus read data
  logic [DAT_W-1:0] dat_d;
  logic             ack_q;
  logic             ack_d;
  tpq_tx_state_t    st_q;                        // Transmit sequencer
  tpq_tx_state_t    st_d;

  // Bus decode
  logic             acc;                         // Request seen this cycle
  logic             wr;
  logic             rd;

  // Memory write port
  logic             mem_we;
  logic [MW-1:0]    mem_wa;
  logic [DAT_W-1:0] mem_wd;
  logic [DAT_W-1:0] mem_rd;                      // Host-side word at pointer
  logic             host_mem_wr;                 // Host data write this cycle

  // Queue controls
  logic             txq_push;
  logic             txq_pop;
  logic [PN_W-1:0]  txq_head;
  logic             txq_full;
  logic             txq_empty;
  logic             cmp_push;
  logic             cmp_pop;
  logic [PN_W-1:0]  cmp_head;
  logic             cmp_full;
  logic             cmp_empty;

  // Allocation search
  logic             free_found;
  logic [PN_W-1:0]  free_pn;
  logic [CNT_W-1:0] req_cnt;

  // Interrupt view with the level-type transmit bit folded in
  logic [2:0]       ipend;

  // Transmit queue, filled by enqueue commands
  tpq_fifo #(.W(PN_W), .D(NPKT)) u_txq (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .push_i  (txq_push),
    .din_i   (pnr_q),
    .pop_i   (txq_pop),
    .head_o  (txq_head),
    .full_o  (txq_full),
    .empty_o (txq_empty)
  );

  // Completion queue, filled as packets finish
  tpq_fifo #(.W(PN_W), .D(NPKT)) u_cmpq (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .push_i  (cmp_push),
    .din_i   (txq_head),
    .pop_i   (cmp_pop),
    .head_o  (cmp_head),
    .full_o  (cmp_full),
    .empty_o (cmp_empty)
  );

  // Lowest free buffer, used by the allocate command
  always_comb begin
    free_found = 1'b0;
    free_pn    = '0;
    for (int i = NPKT - 1; i >= 0; i--) begin
      if (!used_q[i]) begin
        free_found = 1'b1;
        free_pn    = PN_W'(i);
      end
    end
  end

  assign acc      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = acc & wb_we_i;
  assign rd       = acc & ~wb_we_i;
  assign req_cnt  = wb_dat_i[CMD_CNT_LSB +: CNT_W];
  assign mem_rd   = mem_q[{pnr_q, ptr_q}];
  assign host_mem_wr = wr & (wb_adr_i == OFS_DATA);

  // Transmit bit reads as a level of the completion queue
  assign ipend = {istat_q[IRQ_FAIL], ~cmp_empty, istat_q[IRQ_ALLOC]}; // RQ11

  // Register, command and sequencer next state
  always_comb begin
    ctrl_d    = ctrl_q;
    alloc_d   = alloc_q;
    pnr_d     = pnr_q;
    ptr_d     = ptr_q;
    istat_d   = istat_q;
    imask_d   = imask_q;
    used_d    = used_q;
    fail_pn_d = fail_pn_q;
    lstat_d   = lstat_q;
    dat_d     = dat_q;
    st_d      = st_q;
    ack_d     = acc;
    txq_push  = 1'b0;
    txq_pop   = 1'b0;
    cmp_push  = 1'b0;
    cmp_pop   = 1'b0;
    mem_we    = 1'b0;
    mem_wa    = {pnr_q, ptr_q};
    mem_wd    = mem_rd;

    // Host writes; byte lanes matter only for the data window
    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          ctrl_d[CTRL_TXEN] = wb_dat_i[CTRL_TXEN];
          ctrl_d[CTRL_FDX]  = wb_dat_i[CTRL_FDX];
          ctrl_d[CTRL_AREL] = 1'b0; // RQ1
        end
        OFS_CMD: begin
          case (wb_dat_i[2:0])
            CMD_ALLOC: begin
              // One page per packet, so a longer frame cannot be placed
              if (free_found && (req_cnt <= CNT_W'(PG_BYTES))) begin // RQ2
                used_d[free_pn]     = 1'b1; // RQ2
                alloc_d             = {1'b0, 4'h0, free_pn}; // RQ4
                istat_d[IRQ_ALLOC]  = 1'b1; // RQ3
              end else begin
                alloc_d[ALLOC_FAIL] = 1'b1;
              end
            end
            CMD_RELEASE: used_d[pnr_q] = 1'b0; // RQ16
            CMD_ENQUEUE: txq_push = 1'b1; // RQ6
            default: ;
          endcase
        end
        OFS_PNR: pnr_d = wb_dat_i[PN_W-1:0];
        OFS_PTR: ptr_d = wb_dat_i[PTR_W-1:0];
        OFS_DATA: begin
          // Merge only the selected byte lanes, then step the pointer
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
              mem_wd[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
          end
          mem_we = 1'b1;
          ptr_d  = ptr_q + 1'b1;
        end
        OFS_ISTAT: begin
          istat_d[IRQ_ALLOC] = istat_q[IRQ_ALLOC] & ~wb_dat_i[IRQ_ALLOC];
          istat_d[IRQ_FAIL]  = istat_q[IRQ_FAIL] & ~wb_dat_i[IRQ_FAIL];
        end
        OFS_IMASK: imask_d = wb_dat_i[2:0];
        OFS_TXACK: cmp_pop = 1'b1; // RQ17
        default: ;                 // Unmapped writes are dropped
      endcase
    end

    // Host reads, answered one cycle after the request
    if (rd) begin
      case (wb_adr_i)
        OFS_CTRL:  dat_d = {29'h0, ctrl_q};
        OFS_ALLOC: dat_d = {24'h0, alloc_q};
        OFS_PNR:   dat_d = {29'h0, pnr_q};
        OFS_PTR:   dat_d = {26'h0, ptr_q};
        OFS_DATA: begin
          dat_d = mem_rd; // RQ15
          ptr_d = ptr_q + 1'b1;
        end
        OFS_PORTS: begin
          dat_d = 32'h0;
          dat_d[PN_W-1:0]              = cmp_head;
          dat_d[PRT_CMP_EMPTY]         = cmp_empty;
          dat_d[PRT_TX_LSB +: PN_W]    = txq_head;
          dat_d[PRT_TX_EMPTY]          = txq_empty;
          dat_d[PRT_FAIL_LSB +: PN_W]  = fail_pn_q; // RQ13
        end
        OFS_ISTAT: dat_d = {29'h0, ipend};
        OFS_IMASK: dat_d = {29'h0, imask_q};
        OFS_LSTAT: dat_d = lstat_q;
        default:   dat_d = 32'h0;
      endcase
    end

    // Sequencer runs on its own once a number is queued
    case (st_q)
      TX_IDLE: begin
        // Half duplex waits for the deferral process
        if (!txq_empty && ctrl_q[CTRL_TXEN] &&
            (ctrl_q[CTRL_FDX] || mac_defer_ok_i)) begin // RQ8
          st_d = TX_SEND; // RQ7
        end
      end
      TX_SEND: begin
        if (mac_done_i) begin
          lstat_d = mac_status_i;
          st_d    = TX_FINISH;
          if (mac_fail_i) begin
            // Failure wins over a host enable in the same cycle
            ctrl_d[CTRL_TXEN] = 1'b0; // RQ12
            istat_d[IRQ_FAIL] = 1'b1; // RQ12
            fail_pn_d         = txq_head; // RQ13
          end
        end
      end
      TX_FINISH: begin
        // Wait for a free memory port and room in the completion queue
        if (!host_mem_wr && !cmp_full) begin
          mem_we   = 1'b1;
          mem_wa   = {txq_head, {PTR_W{1'b0}}}; // RQ9
          mem_wd   = lstat_q; // RQ9
          txq_pop  = 1'b1; // RQ10
          cmp_push = 1'b1; // RQ10
          st_d     = TX_IDLE; // RQ12
        end
      end
      default: st_d = TX_IDLE;
    endcase
  end

  // Register stage for all control state; buffers stay allocated
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q    <= CTRL_RST;
      alloc_q   <= ALLOC_RST;
      pnr_q     <= '0;
      ptr_q     <= '0;
      istat_q   <= 3'h0;
      imask_q   <= IMASK_RST;
      used_q    <= '0;
      fail_pn_q <= '0;
      lstat_q   <= '0;
      dat_q     <= '0;
      ack_q     <= 1'b0;
      st_q      <= TX_IDLE;
    end else begin
      ctrl_q    <= ctrl_d;
      alloc_q   <= alloc_d;
      pnr_q     <= pnr_d;
      ptr_q     <= ptr_d;
      istat_q   <= istat_d;
      imask_q   <= imask_d;
      used_q    <= used_d; // RQ1
      fail_pn_q <= fail_pn_d;
      lstat_q   <= lstat_d;
      dat_q     <= dat_d;
      ack_q     <= ack_d;
      st_q      <= st_d;
    end
  end

  // Single write port, shared by host data and completion status
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // Frame read port for the MAC
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mac_rd_data_o <= '0;
    end else begin
      mac_rd_data_o <= mem_q[{txq_head, mac_rd_ptr_i}];
    end
  end

  assign wb_dat_o  = dat_q;
  assign wb_ack_o  = ack_q;
  assign mac_req_o = (st_q == TX_SEND); // RQ8
  assign mac_pkt_o = txq_head;
  assign irq_o     = |(ipend & imask_q); // RQ11
endmodule // tpq_queue

`default_nettype wire

/* File: tb/tpq_mac_model.sv */
// Purpose: Behavioural MAC partner.
// Assumes: Queue clock; one packet at a time.
// Notes:   Fail and status show the inverse off done.
`timescale 1ns/1ns
`default_nettype none
module tpq_mac_model
  import tpq_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             req_i,      // Packet handed over
  input  wire logic [DAT_W-1:0] rd_data_i,  // Frame word, one cycle late
  input  wire logic             fail_cmd_i, // Make sends fail
  input  wire logic [3:0]       wait_i,     // Send length, at least 2
  output logic      [PTR_W-1:0] rd_ptr_o,   // Frame word index
  output logic                  done_o,     // Send over, one cycle
  output logic                  fail_o,     // Valid with done only
  output logic      [DAT_W-1:0] status_o,   // Valid with done only
  output logic      [DAT_W-1:0] word1_o     // Second frame word seen
);
  logic [3:0]       cnt_q, cnt_d;   // Cycles on this packet
  logic             done_q, done_d; // Done pulse
  logic             cap_q, cap_d;   // Word 1 arrives now
  logic [DAT_W-1:0] w1_q, w1_d;     // Captured word 1
  logic [DAT_W-1:0] st;             // Status of this send

  assign st       = {fail_cmd_i, 27'h0, wait_i};
  assign rd_ptr_o = {2'h0, cnt_q};
  assign done_o   = done_q;
  // Stale qualifiers must not be trusted
  assign fail_o   = done_q ? fail_cmd_i : ~fail_cmd_i;
  assign status_o = done_q ? st : ~st;
  assign word1_o  = w1_q;

  // Step the pointer, end after the wait
  always_comb begin
    cnt_d  = 4'h0;
    done_d = 1'b0;
    cap_d  = req_i && (cnt_q == 4'h1);
    w1_d   = cap_q ? rd_data_i : w1_q;
    if (req_i && !done_q) begin
      cnt_d  = (cnt_q == wait_i) ? 4'h0 : cnt_q + 4'h1;
      done_d = (cnt_q == wait_i);
    end
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 4'h0;
      done_q <= 1'b0;
      cap_q  <= 1'b0;
      w1_q   <= 32'h0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
      cap_q  <= cap_d;
      w1_q   <= w1_d;
    end
  end
endmodule // tpq_mac_model
`default_nettype wire

/* File: tb/tpq_queue_checker.sv */
// Purpose: Bus and MAC hand-off checks.
// Assumes: One clock; writes shadowed from the bus.
// Notes:   Shadows track bus writes; the enable shadow also clears on a failure.
`timescale 1ns/1ns
`default_nettype none
module tpq_queue_checker
  import tpq_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic             wb_ack_o,
  input wire logic             irq_o,
  input wire logic             mac_req_o,
  input wire logic [PN_W-1:0]  mac_pkt_o,
  input wire logic             mac_defer_ok_i,
  input wire logic             mac_done_i,
  input wire logic             mac_fail_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic       take;          // Write taken at this edge
  logic       fin;           // Packet ends at this edge
  logic       en_q, en_d;    // Enable as the host or a failure left it
  logic       fdx_q, fdx_d;  // Full duplex shadow
  logic [2:0] msk_q, msk_d;  // Mask shadow
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign fin  = mac_req_o && mac_done_i;

  // Shadows; a failure beats a same-edge rewrite
  always_comb begin
    en_d  = en_q;
    fdx_d = fdx_q;
    msk_d = msk_q;
    if (take && wb_adr_i == OFS_CTRL) begin
      en_d  = wb_dat_i[CTRL_TXEN];
      fdx_d = wb_dat_i[CTRL_FDX];
    end
    if (take && wb_adr_i == OFS_IMASK) begin
      msk_d = wb_dat_i[2:0];
    end
    if (fin && mac_fail_i) begin
      en_d = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q  <= 1'b0;
      fdx_q <= 1'b0;
      msk_q <= 3'h0;
    end else begin
      en_q  <= en_d;
      fdx_q <= fdx_d;
      msk_q <= msk_d;
    end
  end

  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  req_hold_a: assert property (mac_req_o && !mac_done_i |=> mac_req_o)
    else $error("hand-off dropped early");
  req_gap_a: assert property (fin |=> !mac_req_o [*2])
    else $error("next hand-off too soon");
  pkt_stable_a: assert property (mac_req_o && $past(mac_req_o) |-> $stable(mac_pkt_o))
    else $error("packet moved");
  start_cond_a: assert property ($rose(mac_req_o) |->
    $past(en_q) && ($past(fdx_q) || $past(mac_defer_ok_i)))
    else $error("hand-off without permission");
  cmp_irq_a: assert property (fin && msk_q[IRQ_TX] |-> ##[2:3] irq_o)
    else $error("no interrupt on completion");
  fail_irq_a: assert property (fin && mac_fail_i && msk_q[IRQ_FAIL] |=> irq_o)
    else $error("no interrupt on failure");

  cover property ($rose(mac_req_o));
  cover property (fin && mac_fail_i);
  cover property ($fell(irq_o));
endmodule // tpq_queue_checker

bind tpq_queue tpq_queue_checker i_tpq_queue_checker (.*);
`default_nettype wire

/* File: tb/tpq_queue_tb.sv */
// Purpose: Bench of the packet queue.
// Assumes: Classic bus tasks; MAC model.
// Notes:   Bench drives deferral.
`timescale 1ns/1ns
`default_nettype none
module tpq_queue_tb
  import tpq_pkg::*;
;
  logic             clk_i = 1'b0; // 25 MHz clock
  logic             rst_i = 1'b1; // Synchronous reset
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, dfr = 1'b0, fcmd = 1'b0;
  logic             ack, irq, req, done, fail;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0]       sel = 4'hf, wt = 4'h4;
  logic [DAT_W-1:0] dat = '0, rdat, st, w1, rdd, q;
  logic [PTR_W-1:0] ptr;
  logic [PN_W-1:0]  pkn, p;
  logic [PN_W-1:0]  pk [NPKT]; // Allocated numbers
  int               error_cnt = 0;
  int               comparisons = 0;
  int               sent = 0;  // Done pulses seen

  tpq_queue i_tpq_queue (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .mac_req_o(req), .mac_pkt_o(pkn), .mac_rd_ptr_i(ptr),
    .mac_rd_data_o(rdd), .mac_defer_ok_i(dfr), .mac_done_i(done), .mac_fail_i(fail),
    .mac_status_i(st));
  tpq_mac_model i_tpq_mac_model (.clk_i, .rst_i, .req_i(req),
    .rd_data_i(rdd), .fail_cmd_i(fcmd), .wait_i(wt), .rd_ptr_o(ptr), .done_o(done),
    .fail_o(fail), .status_o(st), .word1_o(w1));

  always #20 clk_i = ~clk_i;
  // Count finished sends
  always @(posedge clk_i) if (done === 1'b1) sent++;

  task automatic chk(input string s, input logic [DAT_W-1:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // Held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    if (n >= 40) chk("bus ack", 32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [ADR_W-1:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wirq(input logic v);
    int n = 0;
    while (irq !== v && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk("irq", 32'(irq), 32'(v));
  endtask

  // Allocate, poll, clear, read result
  task automatic alloc(input logic [10:0] c, input logic ok, output logic [PN_W-1:0] r);
    int n = 0;
    wr(OFS_CMD, (32'(c) << CMD_CNT_LSB) | 32'(CMD_ALLOC));
    do begin
      rd(OFS_ISTAT);
      n++;
    end while (q[IRQ_ALLOC] !== ok && n < 10);
    chk("alloc flag", 32'(q[IRQ_ALLOC]), 32'(ok));
    wr(OFS_ISTAT, 32'h1);
    rd(OFS_ALLOC);
    chk("alloc fail", 32'(q[ALLOC_FAIL]), 32'(!ok));
    r = q[PN_W-1:0];
  endtask

  task automatic t_regs();
    logic [ADR_W-1:0] a [7] = '{OFS_CTRL, OFS_ALLOC, OFS_PNR, OFS_PTR, OFS_ISTAT,
                                OFS_IMASK, 8'hfc};
    logic [DAT_W-1:0] e [7] = '{32'h0, 32'(ALLOC_RST), 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 7; i++) begin
      rd(a[i]);
      chk("reset value", q, e[i]);
    end
    $display("test regs done");
  endtask

  // Oversize refused, then a frame loaded
  task automatic t_load();
    alloc(11'h101, 1'b0, p);
    alloc(11'h03c, 1'b1, pk[0]);
    wr(OFS_PNR, 32'(pk[0]));
    wr(OFS_PTR, 32'h0);
    for (int i = 0; i < 4; i++) wr(OFS_DATA, 32'hf0f0_0000 + i);
    wr(OFS_PTR, 32'h1);
    rd(OFS_DATA);
    chk("readback", q, 32'hf0f0_0001);
    rd(OFS_PTR);
    chk("ptr step", q, 32'h2);
    $display("test load done");
  endtask

  task automatic t_send();
    wr(OFS_IMASK, 32'h2);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CMD, 32'(CMD_ENQUEUE));
    repeat (8) @(posedge clk_i);
    chk("deferred", 32'(req), 32'h0);
    rd(OFS_PORTS);
    chk("tx head", 32'(q[15:8]), 32'(pk[0]));
    dfr <= 1'b1;
    wirq(1'b1);
    chk("frame word", w1, 32'hf0f0_0001);
    rd(OFS_ISTAT);
    chk("tx bit", 32'(q[IRQ_TX]), 32'h1);
    rd(OFS_PORTS);
    chk("cmp head", 32'(q[7:0]), 32'(pk[0]));
    wr(OFS_PNR, 32'(pk[0]));
    wr(OFS_PTR, 32'h0);
    rd(OFS_DATA);
    chk("status word", q, {28'h0, wt});
    wr(OFS_TXACK, 32'h0);
    wirq(1'b0);
    $display("test send done");
  endtask

  // Buffer held until released
  task automatic t_hold();
    for (int i = 1; i < NPKT; i++) alloc(11'h03c, 1'b1, pk[i]);
    alloc(11'h03c, 1'b0, p);
    wr(OFS_PNR, 32'(pk[0]));
    wr(OFS_CMD, 32'(CMD_RELEASE));
    alloc(11'h03c, 1'b1, p);
    chk("reused buffer", 32'(p), 32'(pk[0]));
    $display("test hold done");
  endtask

  task automatic t_fail();
    logic [PN_W-1:0] e [3] = '{pk[1], pk[2], pk[1]};
    fcmd <= 1'b1;
    wr(OFS_IMASK, 32'h4);
    wr(OFS_CTRL, 32'h5);
    for (int i = 1; i < 3; i++) begin
      wr(OFS_PNR, 32'(pk[i]));
      wr(OFS_CMD, 32'(CMD_ENQUEUE));
    end
    wirq(1'b1);
    repeat (8) @(posedge clk_i);
    chk("halted", 32'(req), 32'h0);
    chk("mac packet", 32'(pkn), 32'(pk[2]));
    rd(OFS_CTRL);
    chk("enable off", 32'(q[CTRL_TXEN]), 32'h0);
    rd(OFS_PORTS);
    chk("failed number", 32'(q[18:16]), 32'(pk[1]));
    chk("tx waiting", 32'(q[15:8]), 32'(pk[2]));
    rd(OFS_LSTAT);
    chk("link status", q, {1'b1, 27'h0, wt});
    fcmd <= 1'b0;
    wr(OFS_ISTAT, 32'h4);
    wirq(1'b0);
    wr(OFS_PNR, 32'(pk[1]));
    wr(OFS_CTRL, 32'h5);
    wr(OFS_CMD, 32'(CMD_ENQUEUE));
    repeat (60) @(posedge clk_i);
    for (int i = 0; i < 3; i++) begin
      rd(OFS_PORTS);
      chk("cmp order", 32'(q[7:0]), 32'(e[i]));
      wr(OFS_TXACK, 32'h0);
    end
    rd(OFS_PORTS);
    chk("cmp empty", 32'(q[PRT_CMP_EMPTY]), 32'h1);
    $display("test fail done");
  endtask

  // Overfill while halted, overdrain after
  task automatic t_full();
    int s0;
    wr(OFS_CTRL, 32'h4);
    wr(OFS_IMASK, 32'h2);
    wr(OFS_PNR, 32'(pk[3]));
    for (int i = 0; i <= NPKT; i++) wr(OFS_CMD, 32'(CMD_ENQUEUE));
    s0 = sent;
    wr(OFS_CTRL, 32'h5);
    repeat (200) @(posedge clk_i);
    chk("sends", 32'(sent - s0), 32'(NPKT));
    for (int i = 0; i <= NPKT; i++) wr(OFS_TXACK, 32'h0);
    wirq(1'b0);
    $display("test full done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_load();
    t_send();
    t_hold();
    t_fail();
    t_full();
    stop_test();
  end

  // Watchdog
  initial begin
    repeat (50000) @(posedge clk_i);
    error_cnt++;
    stop_test();
  end
endmodule // tpq_queue_tb
`default_nettype wire
